// [core/ssot_pkg.sv]
package ssot_pkg;
  // ****************************************************************
  // serial frame
  // ****************************************************************
  localparam int          SSOT_ADDR_W      = 8;
  localparam int          SSOT_DATA_W      = 24;
  localparam int          SSOT_FRAME_W     = SSOT_ADDR_W + SSOT_DATA_W;
  localparam logic [5:0]  SSOT_FRAME_BITS  = 6'h20;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0]  SSOT_TRIGGER_OFS = 8'h51;
  localparam logic [7:0]  SSOT_ROUTING_OFS = 8'h60;
  localparam int          SSOT_TRIGGER_W   = 8;
  localparam int          SSOT_ROUTING_W   = 12;
  localparam logic [7:0]  SSOT_TRIGGER_RST = 8'h00;

  // ****************************************************************
  // routing fields: lsb positions and defaults
  // ****************************************************************
  localparam int          SSOT_SUB_LSB     = 0;
  localparam int          SSOT_MECH_LSB    = 3;
  localparam int          SSOT_STROBE_LSB  = 6;
  localparam int          SSOT_TEST_LSB    = 9;
  localparam int          SSOT_SEL_W       = 3;
  localparam logic [2:0]  SSOT_SUB_RST     = 3'h0;
  localparam logic [2:0]  SSOT_MECH_RST    = 3'h1;
  localparam logic [2:0]  SSOT_STROBE_RST  = 3'h2;
  localparam logic [2:0]  SSOT_TEST_RST    = 3'h3;
  localparam logic [11:0] SSOT_ROUTING_RST = {SSOT_TEST_RST, SSOT_STROBE_RST,
                                              SSOT_MECH_RST, SSOT_SUB_RST};

  // ****************************************************************
  // select codes
  // ****************************************************************
  localparam logic [2:0]  SSOT_SEL_MUX_A   = 3'h4;
  localparam logic [2:0]  SSOT_SEL_MUX_B   = 3'h5;
  localparam logic [2:0]  SSOT_SEL_INVALID = 3'h6;
  localparam logic [2:0]  SSOT_SEL_PAIR    = 3'h7;

  // ****************************************************************
  // trigger bits
  // ****************************************************************
  localparam int          SSOT_TRG_SEQ_A   = 4;
  localparam int          SSOT_TRG_SEQ_B   = 5;
  localparam int          SSOT_TRG_EXPOSE  = 6;
  localparam int          SSOT_TRG_READOUT = 7;

  typedef enum logic [0:0] {
    SSOT_IDLE     = 1'b0,
    SSOT_EXP_WAIT = 1'b1
  } ssot_seq_type;
endpackage

// [core/ssot_serial_port.sv]
module ssot_serial_port
  import ssot_pkg::*;
(
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   sck_i,
  input  wire logic                   sdata_i,
  input  wire logic                   load_n_i,
  output logic                        wr_o,
  output logic [SSOT_ADDR_W-1:0]      addr_o,
  output logic [SSOT_DATA_W-1:0]      data_o
);
  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [2:0]              sync_a;
  logic [2:0]              sync_b;
  logic                    load_d;
  logic [SSOT_FRAME_W-1:0] shift;
  logic [5:0]              count;
  logic [SSOT_FRAME_W-1:0] next_shift;
  logic [5:0]              next_count;
  logic                    next_wr;
  logic                    sck_rise;
  logic                    load_rise;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      sync_a <= 3'h0;
      sync_b <= 3'h7;
    end else begin
      sync_a <= {sync_a[1:0], sck_i};
      sync_b <= {sync_b[1:0], load_n_i};
    end
  end

  // stage 0 feeds stage 1 only; edges use stages 1 and 2
  assign sck_rise  = sync_a[1] & ~sync_a[2];
  assign load_rise = sync_b[1] & ~sync_b[2];
  assign load_d    = sync_b[1];

  logic sdata_s0;
  logic sdata_s1;
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      sdata_s0 <= 1'b0;
      sdata_s1 <= 1'b0;
    end else begin
      sdata_s0 <= sdata_i;
      sdata_s1 <= sdata_s0;
    end
  end

  // ****************************************************************
  // frame shifter: lsb first, address then data
  // ****************************************************************
  always_comb begin
    next_shift = shift;
    next_count = count;
    next_wr    = 1'b0;
    if (load_d) begin
      next_count = 6'h00;
    end else if (sck_rise && count <= SSOT_FRAME_BITS) begin
      // count runs one past a full frame so an extra bit spoils the write
      next_shift = {sdata_s1, shift[SSOT_FRAME_W-1:1]};
      next_count = count + 6'h01;
    end
    // short or long frames are dropped so a glitch never writes
    if (load_rise && count == SSOT_FRAME_BITS) begin
      next_wr = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      shift <= '0;
      count <= 6'h00;
      wr_o  <= 1'b0;
    end else begin
      shift <= next_shift;
      count <= next_count;
      wr_o  <= next_wr;
    end
  end

  assign addr_o = shift[SSOT_ADDR_W-1:0];
  assign data_o = shift[SSOT_FRAME_W-1:SSOT_ADDR_W];
endmodule // ssot_serial_port

// [core/ssot_top.sv]
// Operation
// - substrate bias pin follows source picked by bits 2:0, default code 0
// - codes 0 to 3 route shutter generators 0 to 3
// - code 4 mux a, 5 mux b, 7 pair mux; code 6 invalid
// - mechanical shutter pin follows bits 5:3, default code 1
// - flash strobe pin follows bits 8:6, default code 2
// - test output follows bits 11:9, default code 3
// - writing ones to 8-bit trigger register starts sequences; zeros do nothing
// - trigger bits 0-3 start generators 0-3, bit 4 seq a, bit 5 seq b
// - bit 6 starts exposure, bit 7 readout; both: readout follows exposure end
module ssot_top
  import ssot_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       sck_i,
  input  wire logic       sdata_i,
  input  wire logic       load_n_i,
  input  wire logic       vertical_sync_i,
  input  wire logic [3:0] shutter_gen_i,
  input  wire logic       substrate_mux_a_i,
  input  wire logic       substrate_mux_b_i,
  input  wire logic       shutter_pair_mux_i,
  input  wire logic       exposure_done_i,
  output logic            substrate_bias_out_o,
  output logic            mech_shutter_out_o,
  output logic            flash_strobe_o,
  output logic            test_out_pin_o,
  output logic [3:0]      shutter_gen_start_o,
  output logic            substrate_seq_a_start_o,
  output logic            substrate_seq_b_start_o,
  output logic            exposure_start_o,
  output logic            readout_start_o,
  output logic            trigger_pending_o
);
  // ****************************************************************
  // serial port
  // ****************************************************************
  logic                   wr;
  logic [SSOT_ADDR_W-1:0] addr;
  logic [SSOT_DATA_W-1:0] data;

  ssot_serial_port u_port (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .sck_i     (sck_i),
    .sdata_i   (sdata_i),
    .load_n_i  (load_n_i),
    .wr_o      (wr),
    .addr_o    (addr),
    .data_o    (data)
  );

  // ****************************************************************
  // vertical sync edge
  // ****************************************************************
  logic [2:0] vd_sync;
  logic       vd_edge;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      vd_sync <= 3'h0;
    end else begin
      vd_sync <= {vd_sync[1:0], vertical_sync_i};
    end
  end
  assign vd_edge = vd_sync[1] & ~vd_sync[2];

  function automatic logic pick_source(input logic [2:0] sel,
                                       input logic [3:0] gen,
                                       input logic       mux_a,
                                       input logic       mux_b,
                                       input logic       pair);
    logic r;
    r = 1'b0;
    case (sel)
      SSOT_SEL_MUX_A:   r = mux_a;
      SSOT_SEL_MUX_B:   r = mux_b;
      SSOT_SEL_PAIR:    r = pair;
      // the invalid code parks the pin low rather than guess a source
      SSOT_SEL_INVALID: r = 1'b0;
      default:          r = gen[sel[1:0]];
    endcase
    return r;
  endfunction

  // ****************************************************************
  // registers, staging and routing
  // ****************************************************************
  logic [SSOT_ROUTING_W-1:0] staged_route;
  logic [SSOT_ROUTING_W-1:0] act_route;
  logic [SSOT_TRIGGER_W-1:0] pending;
  logic [SSOT_ROUTING_W-1:0] next_staged_route;
  logic [SSOT_ROUTING_W-1:0] next_act_route;
  logic [SSOT_TRIGGER_W-1:0] next_pending;
  logic [SSOT_TRIGGER_W-1:0] wr_trig;
  logic [3:0]                next_pins;

  always_comb begin
    next_staged_route = staged_route;
    next_act_route    = act_route;
    wr_trig           = '0;
    if (wr && addr == SSOT_ROUTING_OFS) begin
      next_staged_route = data[SSOT_ROUTING_W-1:0];
    end
    if (wr && addr == SSOT_TRIGGER_OFS) begin
      wr_trig = data[SSOT_TRIGGER_W-1:0];
    end
    if (vd_edge) begin
      next_act_route = staged_route;
    end
    // a write landing on the sync edge stays pending, never lost
    next_pending = (vd_edge ? '0 : pending) | wr_trig;
    next_pins[0] = pick_source(act_route[SSOT_SUB_LSB +: SSOT_SEL_W], shutter_gen_i,
                               substrate_mux_a_i, substrate_mux_b_i,
                               shutter_pair_mux_i);
    next_pins[1] = pick_source(act_route[SSOT_MECH_LSB +: SSOT_SEL_W], shutter_gen_i,
                               substrate_mux_a_i, substrate_mux_b_i,
                               shutter_pair_mux_i);
    next_pins[2] = pick_source(act_route[SSOT_STROBE_LSB +: SSOT_SEL_W], shutter_gen_i,
                               substrate_mux_a_i, substrate_mux_b_i,
                               shutter_pair_mux_i);
    next_pins[3] = pick_source(act_route[SSOT_TEST_LSB +: SSOT_SEL_W], shutter_gen_i,
                               substrate_mux_a_i, substrate_mux_b_i,
                               shutter_pair_mux_i);
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      staged_route         <= SSOT_ROUTING_RST;
      act_route            <= SSOT_ROUTING_RST;
      pending              <= SSOT_TRIGGER_RST;
      substrate_bias_out_o <= 1'b0;
      mech_shutter_out_o   <= 1'b0;
      flash_strobe_o       <= 1'b0;
      test_out_pin_o       <= 1'b0;
    end else begin
      staged_route         <= next_staged_route;
      act_route            <= next_act_route;
      pending              <= next_pending;
      substrate_bias_out_o <= next_pins[0];
      mech_shutter_out_o   <= next_pins[1];
      flash_strobe_o       <= next_pins[2];
      test_out_pin_o       <= next_pins[3];
    end
  end

  // ****************************************************************
  // trigger launch and exposure/readout chaining
  // ****************************************************************
  ssot_seq_type seq;
  ssot_seq_type next_seq;
  logic [3:0]   next_gen_start;
  logic         next_seq_a;
  logic         next_seq_b;
  logic         next_expose;
  logic         next_readout;

  always_comb begin
    next_seq       = seq;
    next_gen_start = 4'h0;
    next_seq_a     = 1'b0;
    next_seq_b     = 1'b0;
    next_expose    = 1'b0;
    next_readout   = 1'b0;
    if (vd_edge) begin
      next_gen_start = pending[3:0];
      next_seq_a     = pending[SSOT_TRG_SEQ_A];
      next_seq_b     = pending[SSOT_TRG_SEQ_B];
      next_expose    = pending[SSOT_TRG_EXPOSE];
    end
    case (seq)
      SSOT_IDLE: begin
        if (vd_edge && pending[SSOT_TRG_READOUT]) begin
          if (pending[SSOT_TRG_EXPOSE]) begin
            next_seq = SSOT_EXP_WAIT;
          end else begin
            next_readout = 1'b1;
          end
        end
      end
      default: begin
        // readout held back until the exposure reports done
        if (exposure_done_i) begin
          next_readout = 1'b1;
          next_seq     = SSOT_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      seq                     <= SSOT_IDLE;
      shutter_gen_start_o     <= 4'h0;
      substrate_seq_a_start_o <= 1'b0;
      substrate_seq_b_start_o <= 1'b0;
      exposure_start_o        <= 1'b0;
      readout_start_o         <= 1'b0;
      trigger_pending_o       <= 1'b0;
    end else begin
      seq                     <= next_seq;
      shutter_gen_start_o     <= next_gen_start;
      substrate_seq_a_start_o <= next_seq_a;
      substrate_seq_b_start_o <= next_seq_b;
      exposure_start_o        <= next_expose;
      readout_start_o         <= next_readout;
      trigger_pending_o       <= |next_pending;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sub_route_a: assert property (act_route[2] == 1'b0 && $stable(act_route) |=>
      substrate_bias_out_o == $past(shutter_gen_i[act_route[1:0]]))
    else $error("substrate pin not following selected generator");
  gen_route_a: assert property (act_route[5:3] == 3'h2 |=>
      mech_shutter_out_o == $past(shutter_gen_i[2]))
    else $error("generator two not routed");
  invalid_code_a: assert property (act_route[8:6] == SSOT_SEL_INVALID |=>
      !flash_strobe_o)
    else $error("invalid code drove strobe");
  mech_route_a: assert property (act_route[5:3] == SSOT_SEL_MUX_A |=>
      mech_shutter_out_o == $past(substrate_mux_a_i))
    else $error("mech shutter not following mux a");
  strobe_route_a: assert property (act_route[8:6] == SSOT_SEL_PAIR |=>
      flash_strobe_o == $past(shutter_pair_mux_i))
    else $error("strobe not following pair mux");
  test_route_a: assert property (act_route[11:9] == SSOT_SEL_MUX_B |=>
      test_out_pin_o == $past(substrate_mux_b_i))
    else $error("test out not following mux b");
  zero_write_a: assert property (wr && addr == SSOT_TRIGGER_OFS && data[7:0] == 8'h00
      && !vd_edge |=> pending == $past(pending))
    else $error("zero trigger write changed pending");
  trig_map_a: assert property (vd_edge ##0 pending[SSOT_TRG_SEQ_B] |=>
      substrate_seq_b_start_o && !$past(pending[SSOT_TRG_SEQ_A]) == !substrate_seq_a_start_o)
    else $error("trigger bits mapped wrongly");
  chain_a: assert property (vd_edge && pending[7:6] == 2'h3 |=>
      exposure_start_o && !readout_start_o ##0 (!readout_start_o throughout
      (seq == SSOT_EXP_WAIT && !exposure_done_i)[*1]) ##1 1'b1)
    else $error("readout started before exposure end");
  done_readout_a: assert property (seq == SSOT_EXP_WAIT && exposure_done_i |=>
      readout_start_o && seq == SSOT_IDLE)
    else $error("readout not launched at exposure end");
  vd_hold_a: assert property (!vd_edge |=> $stable(act_route) && !exposure_start_o
      && shutter_gen_start_o == 4'h0)
    else $error("setting took effect away from sync");
endmodule // ssot_top

// [dv/ssot_far_side_model.sv]
module ssot_far_side_model #(
  parameter int DONE_DELAY = 5
) (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [6:0] src_pat_i,
  input  wire logic       exposure_start_i,
  output logic      [3:0] shutter_gen_o,
  output logic            mux_a_o,
  output logic            mux_b_o,
  output logic            pair_o,
  output logic            exposure_done_o
);
  timeunit 1ns;
  timeprecision 1ps;

  int done_cnt;

  // ****************************************************************
  // source levels and exposure completion
  // ****************************************************************
  // sources are registered so they move just after an edge, like real generators
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      {pair_o, mux_b_o, mux_a_o, shutter_gen_o} <= 7'h00;
      done_cnt        <= 0;
      exposure_done_o <= 1'b0;
    end else begin
      {pair_o, mux_b_o, mux_a_o, shutter_gen_o} <= src_pat_i;
      // done is a single pulse, a few cycles late, never at the start edge
      if (exposure_start_i) begin
        done_cnt <= DONE_DELAY;
      end else if (done_cnt != 0) begin
        done_cnt <= done_cnt - 1;
      end
      exposure_done_o <= (done_cnt == 1);
    end
  end
endmodule // ssot_far_side_model

// [dv/ssot_top_tb_top.sv]
module ssot_top_tb_top;
  import ssot_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic       ref_clk_i = 1'b0;
  logic       rst_n_i   = 1'b0;
  logic       sck_i     = 1'b0;
  logic       sdata_i   = 1'b0;
  logic       load_n_i  = 1'b1;
  logic       vs_i      = 1'b0;
  logic [6:0] src_pat   = 7'h00;
  logic [3:0] gen;
  logic       mux_a, mux_b, pair, exp_done;
  logic [3:0] pins;
  logic [3:0] gen_start;
  logic       seq_a, seq_b, exp_start, rd_start, pending;
  logic [7:0] starts;
  int         err_count = 0;
  int         cmp_count = 0;
  int         cyc       = 0;
  int         cnt[8];
  int         t_st[8];
  int         t_done;

  localparam int LIMIT = 20000;

  always #20 ref_clk_i = ~ref_clk_i;

  ssot_top i_dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .sck_i(sck_i), .sdata_i(sdata_i),
    .load_n_i(load_n_i), .vertical_sync_i(vs_i), .shutter_gen_i(gen),
    .substrate_mux_a_i(mux_a), .substrate_mux_b_i(mux_b), .shutter_pair_mux_i(pair),
    .exposure_done_i(exp_done), .substrate_bias_out_o(pins[0]),
    .mech_shutter_out_o(pins[1]), .flash_strobe_o(pins[2]), .test_out_pin_o(pins[3]),
    .shutter_gen_start_o(gen_start), .substrate_seq_a_start_o(seq_a),
    .substrate_seq_b_start_o(seq_b), .exposure_start_o(exp_start),
    .readout_start_o(rd_start), .trigger_pending_o(pending)
  );

  ssot_far_side_model i_far (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .src_pat_i(src_pat),
    .exposure_start_i(exp_start), .shutter_gen_o(gen), .mux_a_o(mux_a),
    .mux_b_o(mux_b), .pair_o(pair), .exposure_done_o(exp_done)
  );

  assign starts = {rd_start, exp_start, seq_b, seq_a, gen_start};

  // ****************************************************************
  // pulse monitor and hang guard
  // ****************************************************************
  always @(posedge ref_clk_i) begin
    cyc++;
    for (int b = 0; b < 8; b++) begin
      if (starts[b] === 1'b1) begin
        cnt[b]++;
        t_st[b] = cyc;
      end
    end
    if (exp_done === 1'b1) t_done = cyc;
    if (cyc == LIMIT) begin
      err_count++;
      report_and_stop();
    end
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic do_reset();
    rst_n_i <= 1'b0;
    step(8);
    rst_n_i <= 1'b1;
    step(3);
  endtask

  // sck phases of 3 clocks keep each bit clear of the 2-flop sync delay
  task automatic ser_write(input logic [7:0] addr, input logic [23:0] data, input int nbits);
    logic [31:0] frame;
    frame = {data, addr};
    load_n_i <= 1'b0;
    step(3);
    for (int i = 0; i < nbits; i++) begin
      sdata_i <= (i < SSOT_FRAME_W) ? frame[i] : 1'b0;
      step(3);
      sck_i   <= 1'b1;
      step(3);
      sck_i   <= 1'b0;
    end
    step(3);
    load_n_i <= 1'b1;
    step(6);
  endtask

  task automatic vsync();
    vs_i <= 1'b1;
    step(4);
    vs_i <= 1'b0;
    step(8);
  endtask

  // code 6 is refused by driving low; 7 picks the pair mux
  function automatic logic exp_pin(input logic [2:0] code, input logic [6:0] p);
    return (code == SSOT_SEL_INVALID) ? 1'b0 : ((code == SSOT_SEL_PAIR) ? p[6] : p[code]);
  endfunction

  task automatic chk_pins(input logic [11:0] r);
    logic [3:0] e;
    for (int k = 0; k < 7; k++) begin
      src_pat <= 7'(1 << k);
      step(4);
      @(negedge ref_clk_i);
      for (int f = 0; f < 4; f++) e[f] = exp_pin(r[3*f +: 3], 7'(1 << k));
      chk(pins, e);
      @(posedge ref_clk_i);
    end
  endtask

  task automatic run_trig(input logic [7:0] m1, input logic [7:0] m2);
    logic [7:0] seen;
    int         sum;
    @(negedge ref_clk_i);
    foreach (cnt[b]) cnt[b] = 0;
    @(posedge ref_clk_i);
    ser_write(SSOT_TRIGGER_OFS, {16'h0000, m1}, 32);
    if (m2 != 8'h00) ser_write(SSOT_TRIGGER_OFS, {16'h0000, m2}, 32);
    @(negedge ref_clk_i);
    chk(pending, ((m1 | m2) != 8'h00));
    chk(starts, 8'h00);
    @(posedge ref_clk_i);
    vsync();
    step(20);
    @(negedge ref_clk_i);
    sum = 0;
    for (int b = 0; b < 8; b++) begin
      seen[b] = (cnt[b] != 0);
      sum += cnt[b];
    end
    chk(seen, m1 | m2);
    chk(sum, $countones(m1 | m2));
    chk(pending, 1'b0);
  endtask

  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial begin
    logic [11:0] r, prev;
    do_reset();
    @(negedge ref_clk_i);
    chk(pending, 1'b0);
    @(posedge ref_clk_i);
    chk_pins(SSOT_ROUTING_RST);
    $display("test defaults done");

    prev = SSOT_ROUTING_RST;
    for (int v = 0; v < 8; v++) begin
      r = {3'(v + 3), 3'(v + 2), 3'(v + 1), 3'(v)};
      ser_write(SSOT_ROUTING_OFS, {12'h000, r}, 32);
      chk_pins(prev);
      vsync();
      chk_pins(r);
      prev = r;
    end
    $display("test routing done");

    // unmapped address, a short and a long frame must leave routing alone
    ser_write(8'h52, 24'h000FFF, 32);
    ser_write(SSOT_ROUTING_OFS, 24'h000FFF, 31);
    ser_write(SSOT_ROUTING_OFS, 24'h000FFF, 33);
    vsync();
    chk_pins(prev);
    $display("test refused frames done");

    do_reset();
    chk_pins(SSOT_ROUTING_RST);
    $display("test second reset done");

    run_trig(8'h00, 8'h00);
    for (int i = 0; i < 8; i++) run_trig(8'(1 << i), 8'h00);
    run_trig(8'h01, 8'h02);
    run_trig(8'hC0, 8'h00);
    chk((t_st[7] > t_done) && (t_st[7] <= t_done + 2), 1'b1);
    chk(t_done > t_st[6], 1'b1);
    $display("test triggers done");
    report_and_stop();
  end
endmodule // ssot_top_tb_top
